// File: rtl/cscu_cond.sv
// Condition evaluator for the set-conditional codes.
// Assumes the caller folds codes 20..31 onto 4..15 by dropping bit 4.
`timescale 1ns/1ps
module cscu_cond (
  input  wire logic [3:0] sel,
  input  wire logic       f_n,
  input  wire logic       f_z,
  input  wire logic       f_v,
  input  wire logic       f_c,
  output logic            hit
);

  // Selectors below 4 never reach a conditional result
  always_comb begin
    case (sel)
      4'h4:    hit = f_n | f_z;
      4'h5:    hit = ~f_n & ~f_z;
      4'h6:    hit = f_n;
      4'h7:    hit = ~f_n;
      4'h8:    hit = f_c | f_z;
      4'h9:    hit = ~f_c & ~f_z;
      4'ha:    hit = f_c;
      4'hb:    hit = ~f_c;
      4'hc:    hit = f_z;
      4'hd:    hit = ~f_z;
      4'he:    hit = f_v;
      4'hf:    hit = ~f_v;
      default: hit = 1'b0;
    endcase
  end

endmodule

// File: rtl/cscu_lzc.sv
// Leading-zero counter for one operand word.
// Assumes a purely combinational use; the caller registers the count.
`timescale 1ns/1ps
module cscu_lzc #(
  parameter int unsigned W  = 32,
  parameter int unsigned CW = 6
) (
  input  wire logic [W-1:0]  val,
  output logic      [CW-1:0] cnt
);

  // Highest set bit wins because it is visited last; zero word gives W
  always_comb begin
    cnt = CW'(W);
    for (int i = 0; i < W; i++) begin
      if (val[i]) begin
        cnt = CW'(W - 1 - i);
      end
    end
  end

endmodule

// File: rtl/cscu_pkg.sv
// Shared constants and types of the compare and set-condition unit.
// Assumes one core clock; all users refer to names as cscu_pkg::name.
package cscu_pkg;

  // Operand width and bit positions
  localparam int unsigned DW       = 32;
  localparam int unsigned LZ_W     = 6;
  localparam int unsigned FRAME_LO = 25;
  localparam int unsigned SP_HI    = 9;
  localparam int unsigned SP_CHK   = 8;
  localparam int unsigned SR_BIT   = 31;

  // Position of each flag inside the four-bit flag vector
  localparam int unsigned F_N = 3;
  localparam int unsigned F_Z = 2;
  localparam int unsigned F_V = 1;
  localparam int unsigned F_C = 0;

  // Flag write masks
  localparam logic [3:0] FW_ALL  = 4'hf;
  localparam logic [3:0] FW_ZERO = 4'h4;
  localparam logic [3:0] FW_NONE = 4'h0;

  // Set group selector values with fixed meaning
  localparam logic [4:0] N_FRAME = 5'h00;
  localparam logic [4:0] N_ONE   = 5'h02;
  localparam logic [4:0] N_ZERO  = 5'h03;
  localparam logic [4:0] N_ONES  = 5'h12;
  localparam logic [4:0] N_RSV1  = 5'h01;
  localparam logic [4:0] N_RSV16 = 5'h10;
  localparam logic [4:0] N_RSV17 = 5'h11;
  localparam logic [4:0] N_RSV19 = 5'h13;

  // Values after reset
  localparam logic [31:0] RST_DATA  = 32'h0000_0000;
  localparam logic [3:0]  RST_FLAGS = 4'h0;

  // Operation selector from instruction decode
  typedef enum logic [2:0] {
    OP_BOUND_CHECK  = 3'h0,
    OP_COMPARE_REG  = 3'h1,
    OP_COMPARE_IMM  = 3'h2,
    OP_BIT_TEST_REG = 3'h3,
    OP_BIT_TEST_IMM = 3'h4,
    OP_LEAD_ZERO    = 3'h5,
    OP_SET_GROUP    = 3'h6
  } cscu_op_e;

endpackage

// File: rtl/cscu_top.sv
// Compare and set-condition execution unit: one operation per cycle,
// result and flags registered one cycle after the request.
// Assumes decode and register file on the same clock drive all inputs.
// Function
// - Bound check local zero pair never traps
// - Compare subtracts, sets flags, writes nothing
// - Zero equal, carry borrow, overflow signed
// - Negative is true signed less-than
// - Status register source means subtract carry
// - Bit test ANDs, zero flag from result
// - Leading zero count, 32 when zero
// - Frame address from stack and frame pointer
// - Frame address changes no flags
// - Set group decode by n and register
// - Set codes 2,3,18 fixed; 1,16,17,19 reserved
// - Codes 8..11 test carry and zero
// - Codes 12..15 test zero and overflow
// - Codes 20..31 write all ones instead
// - Zero pointer check traps on zero only
`timescale 1ns/1ps
module cscu_top (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              op_valid,
  input  wire cscu_pkg::cscu_op_e op_code,
  input  wire logic [31:0]       dst_val,
  input  wire logic [31:0]       src_val,
  input  wire logic [31:0]       imm_val,
  input  wire logic [4:0]        n_field,
  input  wire logic              reg_is_sr,
  input  wire logic              reg_is_pc,
  input  wire logic              dst_is_local0,
  input  wire logic              src_is_local0,
  input  wire logic [31:0]       sp_val,
  input  wire logic [31:0]       sr_val,
  input  wire logic              flag_n_in,
  input  wire logic              flag_z_in,
  input  wire logic              flag_v_in,
  input  wire logic              flag_c_in,
  output logic                   res_valid,
  output logic                   dst_wr,
  output logic [31:0]            dst_data,
  output logic [3:0]             flags_wr,
  output logic [3:0]             flags_out,
  output logic                   range_trap,
  output logic                   fetch_sel,
  output logic                   reserved_op
);

  // Whole state of the unit in one record
  typedef struct packed {
    logic        vld;
    logic        wr;
    logic [31:0] data;
    logic [3:0]  fwr;
    logic [3:0]  flags;
    logic        trap;
    logic        fetch;
    logic        rsvd;
  } cscu_state_s;

  cscu_state_s s_q;
  cscu_state_s s_d;

  logic [3:0]  flags_in;
  logic [31:0] cmp_src;
  logic [32:0] diff;
  logic        ovf;
  logic [31:0] frame_base;
  logic [31:0] frame_addr;
  logic        frame_carry;
  logic        any_byte_zero;
  logic [31:0] and_src;
  logic [5:0]  lz_cnt;
  logic        cond_hit;

  assign flags_in = {flag_n_in, flag_z_in, flag_v_in, flag_c_in};

  // Compare operand; status register as source stands for the carry
  always_comb begin
    if (op_code == cscu_pkg::OP_COMPARE_IMM) begin
      cmp_src = imm_val;
    end else if (reg_is_sr) begin
      cmp_src = {31'h0000_0000, flag_c_in};
    end else begin
      cmp_src = src_val;
    end
  end

  // One subtractor serves both compare forms; bit 32 is the borrow
  assign diff = {1'b0, dst_val} - {1'b0, cmp_src};
  assign ovf  = (dst_val[31] ^ cmp_src[31]) & (dst_val[31] ^ diff[31]);

  // Frame address: carry into bit 9 when the frame wraps a 512 block
  assign frame_carry = sp_val[cscu_pkg::SP_CHK] &
                       ~sr_val[cscu_pkg::SR_BIT];
  assign frame_base  = {sp_val[31:cscu_pkg::SP_HI],
                        sr_val[31:cscu_pkg::FRAME_LO], 2'b00};
  assign frame_addr  = frame_base +
                       {22'h00_0000, frame_carry, 9'h000};

  // Byte-wise zero test used by the immediate bit test with selector 0
  assign any_byte_zero = (dst_val[31:24] == 8'h00) |
                         (dst_val[23:16] == 8'h00) |
                         (dst_val[15:8]  == 8'h00) |
                         (dst_val[7:0]   == 8'h00);

  assign and_src = (op_code == cscu_pkg::OP_BIT_TEST_IMM) ?
                   imm_val : src_val;

  // Leading zero counter
  cscu_lzc #(
    .W  (cscu_pkg::DW),
    .CW (cscu_pkg::LZ_W)
  ) u_lzc (
    .val (src_val),
    .cnt (lz_cnt)
  );

  // Codes 20..31 reuse the evaluator of 4..15 by dropping bit 4
  cscu_cond u_cond (
    .sel (n_field[3:0]),
    .f_n (flag_n_in),
    .f_z (flag_z_in),
    .f_v (flag_v_in),
    .f_c (flag_c_in),
    .hit (cond_hit)
  );

  // Next state; pulses default low and flags default to the incoming flag inputs
  always_comb begin
    s_d       = '0;
    s_d.data  = s_q.data;
    s_d.flags = flags_in;
    s_d.vld   = op_valid;
    if (op_valid) begin
      case (op_code)
        cscu_pkg::OP_BOUND_CHECK: begin
          // Nothing is written; only a trap can leave this operation
          if (dst_is_local0 && src_is_local0) begin
            s_d.trap = 1'b0;
          end else if (reg_is_sr) begin
            s_d.trap = (dst_val == 32'h0000_0000);
          end else if (reg_is_pc) begin
            s_d.trap = (dst_val >= src_val);
          end else begin
            s_d.trap = (dst_val > src_val);
          end
        end
        cscu_pkg::OP_COMPARE_REG, cscu_pkg::OP_COMPARE_IMM: begin
          s_d.fwr                 = cscu_pkg::FW_ALL;
          s_d.flags[cscu_pkg::F_Z] = (diff[31:0] == 32'h0);
          s_d.flags[cscu_pkg::F_C] = diff[32];
          s_d.flags[cscu_pkg::F_V] = ovf;
          s_d.flags[cscu_pkg::F_N] = diff[31] ^ ovf;
        end
        cscu_pkg::OP_BIT_TEST_REG, cscu_pkg::OP_BIT_TEST_IMM: begin
          s_d.fwr = cscu_pkg::FW_ZERO;
          if (op_code == cscu_pkg::OP_BIT_TEST_IMM &&
              n_field == cscu_pkg::N_FRAME) begin
            s_d.flags[cscu_pkg::F_Z] = any_byte_zero;
          end else begin
            s_d.flags[cscu_pkg::F_Z] =
              ((dst_val & and_src) == 32'h0);
          end
        end
        cscu_pkg::OP_LEAD_ZERO: begin
          s_d.wr   = 1'b1;
          s_d.data = {26'h000_0000, lz_cnt};
        end
        cscu_pkg::OP_SET_GROUP: begin
          // Flags are never written from this group
          if (reg_is_sr) begin
            s_d.fetch = 1'b1;
          end else if (reg_is_pc) begin
            s_d.rsvd = 1'b1;
          end else if (n_field == cscu_pkg::N_FRAME) begin
            s_d.wr   = 1'b1;
            s_d.data = frame_addr;
          end else if (n_field == cscu_pkg::N_RSV1  ||
                       n_field == cscu_pkg::N_RSV16 ||
                       n_field == cscu_pkg::N_RSV17 ||
                       n_field == cscu_pkg::N_RSV19) begin
            s_d.rsvd = 1'b1;
          end else if (n_field == cscu_pkg::N_ONE) begin
            s_d.wr   = 1'b1;
            s_d.data = 32'h0000_0001;
          end else if (n_field == cscu_pkg::N_ZERO) begin
            s_d.wr   = 1'b1;
            s_d.data = 32'h0000_0000;
          end else if (n_field == cscu_pkg::N_ONES) begin
            s_d.wr   = 1'b1;
            s_d.data = 32'hffff_ffff;
          end else begin
            s_d.wr   = 1'b1;
            if (!cond_hit) begin
              s_d.data = 32'h0000_0000;
            end else if (n_field[4]) begin
              s_d.data = 32'hffff_ffff;
            end else begin
              s_d.data = 32'h0000_0001;
            end
          end
        end
        default: begin
          s_d.rsvd = 1'b1;
        end
      endcase
    end
  end

  // State register; data is held between writes to save toggling
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.data  <= cscu_pkg::RST_DATA;
      s_q.flags <= cscu_pkg::RST_FLAGS;
    end else begin
      s_q <= s_d;
    end
  end

  assign res_valid   = s_q.vld;
  assign dst_wr      = s_q.wr;
  assign dst_data    = s_q.data;
  assign flags_wr    = s_q.fwr;
  assign flags_out   = s_q.flags;
  assign range_trap  = s_q.trap;
  assign fetch_sel   = s_q.fetch;
  assign reserved_op = s_q.rsvd;

  // Checks on the registered answer against the request a cycle earlier
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  nop_no_trap_a: assert property (
    op_valid && op_code == cscu_pkg::OP_BOUND_CHECK &&
    dst_is_local0 && src_is_local0
    |=> !range_trap && !dst_wr && flags_wr == 4'h0)
    else $error("bound check on local zero pair acted");

  cmp_no_write_a: assert property (
    op_valid && (op_code == cscu_pkg::OP_COMPARE_REG ||
                 op_code == cscu_pkg::OP_COMPARE_IMM)
    |=> !dst_wr && flags_wr == 4'hf)
    else $error("compare wrote a register or missed flags");

  cmp_zc_flags_a: assert property (
    op_valid && op_code == cscu_pkg::OP_COMPARE_REG && !reg_is_sr
    |=> flags_out[2] == ($past(dst_val) == $past(src_val)) &&
        flags_out[0] == ($past(dst_val) < $past(src_val)))
    else $error("compare zero or carry flag wrong");

  cmp_sign_lt_a: assert property (
    op_valid && op_code == cscu_pkg::OP_COMPARE_IMM
    |=> flags_out[3] ==
        ($signed($past(dst_val)) < $signed($past(imm_val))))
    else $error("compare negative flag not signed less-than");

  cmp_carry_src_a: assert property (
    op_valid && op_code == cscu_pkg::OP_COMPARE_REG && reg_is_sr
    |=> flags_out[2] == ($past(dst_val) == {31'h0, $past(flag_c_in)}))
    else $error("compare with status source did not use carry");

  bit_test_z_a: assert property (
    op_valid && op_code == cscu_pkg::OP_BIT_TEST_REG
    |=> flags_wr == 4'h4 && !dst_wr &&
        flags_out[2] == (($past(dst_val) & $past(src_val)) == 32'h0))
    else $error("bit test zero flag wrong");

  byte_zero_a: assert property (
    op_valid && op_code == cscu_pkg::OP_BIT_TEST_IMM && n_field == 5'h00
    |=> flags_wr == 4'h4 &&
        flags_out[2] == ($past(dst_val[31:24]) == 8'h00 ||
                         $past(dst_val[23:16]) == 8'h00 ||
                         $past(dst_val[15:8]) == 8'h00 ||
                         $past(dst_val[7:0]) == 8'h00))
    else $error("any byte zero test gave a wrong zero flag");

  lead_zero_a: assert property (
    op_valid && op_code == cscu_pkg::OP_LEAD_ZERO && src_val == 32'h0
    |=> dst_wr && dst_data == 32'h0000_0020 && flags_wr == 4'h0)
    else $error("leading zero count of zero word is not 32");

  frame_addr_a: assert property (
    op_valid && op_code == cscu_pkg::OP_SET_GROUP && n_field == 5'h00 &&
    !reg_is_sr && !reg_is_pc
    |=> dst_wr && flags_wr == 4'h0 && dst_data[8:0] ==
        {$past(sr_val[31:25]), 2'b00})
    else $error("frame address low field wrong");

  set_decode_a: assert property (
    op_valid && op_code == cscu_pkg::OP_SET_GROUP && reg_is_sr
    |=> fetch_sel && !dst_wr && !reserved_op)
    else $error("set group naming status register not a fetch");

  set_reserved_a: assert property (
    op_valid && op_code == cscu_pkg::OP_SET_GROUP && !reg_is_sr &&
    !reg_is_pc && n_field == 5'h11
    |=> reserved_op && !dst_wr)
    else $error("reserved set code wrote a register");

  set_cond_a: assert property (
    op_valid && op_code == cscu_pkg::OP_SET_GROUP && !reg_is_sr &&
    !reg_is_pc && n_field == 5'h0c
    |=> dst_wr && flags_wr == 4'h0 &&
        dst_data == {31'h0, $past(flag_z_in)})
    else $error("set on zero code gave wrong value");

  set_mask_a: assert property (
    op_valid && op_code == cscu_pkg::OP_SET_GROUP && !reg_is_sr &&
    !reg_is_pc && n_field == 5'h1e
    |=> dst_data == ($past(flag_v_in) ? 32'hffff_ffff : 32'h0))
    else $error("all-ones overflow code gave wrong value");

  zero_ptr_a: assert property (
    op_valid && op_code == cscu_pkg::OP_BOUND_CHECK && reg_is_sr &&
    !(dst_is_local0 && src_is_local0)
    |=> range_trap == ($past(dst_val) == 32'h0) && !dst_wr)
    else $error("zero pointer check trap wrong");

endmodule

// File: sim/cscu_dec_model.sv
// Request driver standing in for instruction decode and the register file.
// Assumes the unit samples a request on the rising edge of ref_clk.
`timescale 1ns/1ps
module cscu_dec_model (
  input  wire logic         ref_clk,
  output cscu_pkg::cscu_op_e op_code,
  output logic              op_valid,
  output logic [31:0]       dst_val,
  output logic [31:0]       src_val,
  output logic [31:0]       imm_val,
  output logic [4:0]        n_field,
  output logic              reg_is_sr,
  output logic              reg_is_pc,
  output logic              dst_is_local0,
  output logic              src_is_local0,
  output logic [31:0]       sp_val,
  output logic [31:0]       sr_val,
  output logic              flag_n_in,
  output logic              flag_z_in,
  output logic              flag_v_in,
  output logic              flag_c_in
);
  // Quiet drive from time zero
  initial begin
    op_code = cscu_pkg::OP_BOUND_CHECK;
    {op_valid, dst_val, src_val, imm_val, n_field} = '0;
    {reg_is_sr, reg_is_pc, dst_is_local0, src_is_local0} = '0;
    {sp_val, sr_val, flag_n_in, flag_z_in, flag_v_in, flag_c_in} = '0;
  end

  // One request, answer settled on return; operands are inverted when
  // idle so a stale value can never pass for a fresh one
  task automatic send(input cscu_pkg::cscu_op_e op, input logic [31:0] d,
                      input logic [31:0] s, input logic [31:0] i,
                      input logic [4:0] n, input logic [3:0] fl,
                      input logic [3:0] rg, input logic [31:0] sp = 32'h0,
                      input logic [31:0] sr = 32'h0);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= op;
    {dst_val, src_val, imm_val, n_field} <= {d, s, i, n};
    {flag_n_in, flag_z_in, flag_v_in, flag_c_in} <= fl;
    {dst_is_local0, src_is_local0, reg_is_pc, reg_is_sr} <= rg;
    {sp_val, sr_val} <= {sp, sr};
    @(posedge ref_clk);
    op_valid <= 1'b0;
    {dst_val, src_val, imm_val} <= ~{d, s, i};
    {sp_val, sr_val} <= ~{sp, sr};
    {flag_n_in, flag_z_in, flag_v_in, flag_c_in} <= ~fl;
    #1;
  endtask
endmodule

// File: sim/tb_compare_and_set_condition_unit.sv
// Self-checking bench for the compare and set-condition unit.
// Assumes the decode model drives every request and the unit answers
// one cycle later.
`timescale 1ns/1ps
`define EXPECT(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_compare_and_set_condition_unit;
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  cscu_pkg::cscu_op_e op_code;
  logic               op_valid, reg_is_sr, reg_is_pc, dst_is_local0;
  logic               src_is_local0, flag_n_in, flag_z_in, flag_v_in;
  logic               flag_c_in, res_valid, dst_wr, range_trap, fetch_sel;
  logic               reserved_op;
  logic [31:0]        dst_val, src_val, imm_val, sp_val, sr_val, dst_data;
  logic [4:0]         n_field;
  logic [3:0]         flags_wr, flags_out;
  int                 n_fail = 0;
  int                 checks_done = 0;

  // 250 MHz core clock
  always #2 ref_clk = ~ref_clk;

  cscu_dec_model P (.ref_clk, .op_code, .op_valid, .dst_val, .src_val,
    .imm_val, .n_field, .reg_is_sr, .reg_is_pc, .dst_is_local0,
    .src_is_local0, .sp_val, .sr_val, .flag_n_in, .flag_z_in, .flag_v_in,
    .flag_c_in);
  cscu_top DUT (.ref_clk, .rst_n, .op_valid, .op_code, .dst_val, .src_val,
    .imm_val, .n_field, .reg_is_sr, .reg_is_pc, .dst_is_local0,
    .src_is_local0, .sp_val, .sr_val, .flag_n_in, .flag_z_in, .flag_v_in,
    .flag_c_in, .res_valid, .dst_wr, .dst_data, .flags_wr, .flags_out,
    .range_trap, .fetch_sel, .reserved_op);

  // Expected {N,Z,V,C} of a subtraction; N is the true signed less-than
  function automatic logic [3:0] cmpf(logic [31:0] a, logic [31:0] b);
    logic [31:0] r;
    logic        v;
    r = a - b;
    v = (a[31] != b[31]) && (r[31] != a[31]);
    return {r[31] ^ v, r == 32'h0, v, a < b};
  endfunction

  // Expected truth of a set code 4..15 against flags {N,Z,V,C}
  function automatic logic cond(logic [3:0] s, logic [3:0] f);
    logic x;
    logic t;
    x = (s[3:2] == 2'h1) ? f[3] : f[0];
    if (s[3:2] == 2'h3) t = s[1] ? f[1] : f[2];
    else t = s[1] ? x : (x | f[2]);
    return t ^ s[0];
  endfunction

  // Local zero pair never traps, with program counter or status source too
  task automatic t_check();
    P.send(cscu_pkg::OP_BOUND_CHECK, 32'h9, 32'h1, 32'h0, 5'h0, 4'h0, 4'he);
    `EXPECT("res valid", 1'b1, res_valid)
    `EXPECT("nop trap", 1'b0, range_trap)
    `EXPECT("nop write", {1'b0, 4'h0}, {dst_wr, flags_wr})
    P.send(cscu_pkg::OP_BOUND_CHECK, 32'h0, 32'h0, 32'h0, 5'h0, 4'h0, 4'hd);
    `EXPECT("nop sr trap", 1'b0, range_trap)
    P.send(cscu_pkg::OP_BOUND_CHECK, 32'h0, 32'h5, 32'h0, 5'h0, 4'h0, 4'h1);
    `EXPECT("zero trap", 1'b1, range_trap)
    `EXPECT("zero write", {1'b0, 4'h0}, {dst_wr, flags_wr})
    P.send(cscu_pkg::OP_BOUND_CHECK, 32'h3, 32'h0, 32'h0, 5'h0, 4'h0, 4'h1);
    `EXPECT("nonzero trap", 1'b0, range_trap)
    P.send(cscu_pkg::OP_BOUND_CHECK, 32'h9, 32'h1, 32'h0, 5'h0, 4'h0, 4'h0);
    `EXPECT("upper bound trap", 1'b1, range_trap)
    P.send(cscu_pkg::OP_BOUND_CHECK, 32'h5, 32'h5, 32'h0, 5'h0, 4'h0, 4'h0);
    `EXPECT("in bound trap", 1'b0, range_trap)
    P.send(cscu_pkg::OP_BOUND_CHECK, 32'h5, 32'h5, 32'h0, 5'h0, 4'h0, 4'h2);
    `EXPECT("pc bound trap", 1'b1, range_trap)
    P.send(cscu_pkg::cscu_op_e'(3'h7), 32'h0, 32'h0, 32'h0, 5'h0, 4'h0,
           4'h0);
    `EXPECT("bad op", {1'b1, 1'b0, 4'h0}, {reserved_op, dst_wr, flags_wr})
  endtask

  // Compares at sign and overflow boundaries, register and immediate
  task automatic t_cmp();
    logic [31:0] a [5] = '{32'h5, 32'h8000_0000, 32'h7, 32'h7fff_ffff, 32'h0};
    logic [31:0] b [5] = '{32'h7, 32'h1, 32'h7, 32'hffff_ffff, 32'h8000_0000};
    for (int k = 0; k < 5; k++) begin
      P.send(cscu_pkg::OP_COMPARE_REG, a[k], b[k], ~b[k], 5'h1, 4'h0, 4'h0);
      `EXPECT("cmp flags", cmpf(a[k], b[k]), flags_out)
      `EXPECT("cmp write", {1'b0, 4'hf}, {dst_wr, flags_wr})
      P.send(cscu_pkg::OP_COMPARE_IMM, a[k], ~b[k], b[k], 5'h1, 4'hf, 4'h1);
      `EXPECT("compare_imm flags", cmpf(a[k], b[k]), flags_out)
    end
    for (int c = 0; c < 2; c++) begin
      P.send(cscu_pkg::OP_COMPARE_REG, 32'h0, 32'h5, 32'h0, 5'h1,
             {3'h0, c[0]}, 4'h1);
      `EXPECT("cmp carry", cmpf(32'h0, {31'h0, c[0]}), flags_out)
    end
  endtask

  // Bit tests, including the any-byte-zero selector
  task automatic t_bit();
    P.send(cscu_pkg::OP_BIT_TEST_REG, 32'hf0, 32'h0f, 32'h0, 5'h1, 4'hb, 4'h0);
    `EXPECT("bt flags", 4'hf, flags_out)
    `EXPECT("bt mask", {1'b0, 4'h4}, {dst_wr, flags_wr})
    P.send(cscu_pkg::OP_BIT_TEST_REG, 32'hf0, 32'h10, 32'h0, 5'h1, 4'h4, 4'h0);
    `EXPECT("bt nz", 4'h0, flags_out)
    P.send(cscu_pkg::OP_BIT_TEST_IMM, 32'h8000_0000, 32'h0, 32'h8000_0000,
           5'h1, 4'h4, 4'h0);
    `EXPECT("bti nz", 4'h0, flags_out)
    P.send(cscu_pkg::OP_BIT_TEST_IMM, 32'h1100_3344, 32'h0, 32'hffff_ffff,
           5'h0, 4'h0, 4'h0);
    `EXPECT("byte zero", 4'h4, flags_out)
    P.send(cscu_pkg::OP_BIT_TEST_IMM, 32'h1122_3344, 32'h0, 32'h0,
           5'h0, 4'h4, 4'h0);
    `EXPECT("no byte zero", 4'h0, flags_out)
  endtask

  // Leading zero counts at both ends of the range
  task automatic t_lz();
    logic [31:0] v [4] = '{32'h0, 32'h1, 32'h8000_0000, 32'h0001_ffff};
    logic [31:0] e [4] = '{32'h20, 32'h1f, 32'h0, 32'hf};
    for (int k = 0; k < 4; k++) begin
      P.send(cscu_pkg::OP_LEAD_ZERO, ~v[k], v[k], 32'h0, 5'h1, 4'h6, 4'h0);
      `EXPECT("lz count", e[k], dst_data)
      `EXPECT("lz write", {1'b1, 4'h0}, {dst_wr, flags_wr})
    end
  endtask

  // Frame address with and without the carry into bit 9
  task automatic t_frame();
    logic [31:0] s [3] = '{32'h0001_ff00, 32'h1234_5f00, 32'h1234_5e00};
    logic [31:0] r [3] = '{32'h5400_0000, 32'hd400_0000, 32'h2a00_0000};
    logic [31:0] e;
    for (int k = 0; k < 3; k++) begin
      e = {s[k][31:9], r[k][31:25], 2'h0};
      e = e + ((s[k][8] & ~r[k][31]) ? 32'h200 : 32'h0);
      P.send(cscu_pkg::OP_SET_GROUP, 32'h0, 32'h0, 32'h0, 5'h0, 4'h9, 4'h0,
             s[k], r[k]);
      `EXPECT("frame addr", e, dst_data)
      `EXPECT("frame write", {1'b1, 4'h0}, {dst_wr, flags_wr})
      `EXPECT("frame sel", {1'b0, 1'b0}, {fetch_sel, reserved_op})
    end
  endtask

  // Set codes 1..31 against every flag pattern, then the register forms
  task automatic t_set();
    logic [31:0] e;
    for (int f = 0; f < 16; f++) begin
      for (int n = 1; n < 32; n++) begin
        e = (cond(n[3:0], f[3:0]) ? (n[4] ? 32'hffff_ffff : 32'h1) : 32'h0);
        if (n == 2) e = 32'h1;
        if (n == 3) e = 32'h0;
        if (n == 18) e = 32'hffff_ffff;
        P.send(cscu_pkg::OP_SET_GROUP, 32'h0, 32'h0, 32'h0, n[4:0], f[3:0],
               4'h0);
        if (n == 1 || n == 16 || n == 17 || n == 19) begin
          `EXPECT("set rsv", {1'b1, 1'b0}, {reserved_op, dst_wr})
        end else begin
          `EXPECT("set value", e, dst_data)
          `EXPECT("set write", {1'b1, 4'h0}, {dst_wr, flags_wr})
        end
      end
    end
    P.send(cscu_pkg::OP_SET_GROUP, 32'h0, 32'h0, 32'h0, 5'h0, 4'h0, 4'h1);
    `EXPECT("fetch", 1'b1, fetch_sel)
    P.send(cscu_pkg::OP_SET_GROUP, 32'h0, 32'h0, 32'h0, 5'h5, 4'h0, 4'h3);
    `EXPECT("fetch pc", 1'b1, fetch_sel)
    P.send(cscu_pkg::OP_SET_GROUP, 32'h0, 32'h0, 32'h0, 5'h5, 4'h0, 4'h2);
    `EXPECT("pc rsv", {1'b1, 1'b0}, {reserved_op, dst_wr})
  endtask

  // Reset in mid-run clears the held result, the flags and the pulses
  task automatic t_rst();
    P.send(cscu_pkg::OP_SET_GROUP, 32'h0, 32'h0, 32'h0, 5'h12, 4'h0, 4'h0);
    `EXPECT("ones before reset", 32'hffff_ffff, dst_data)
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    `EXPECT("reset data", cscu_pkg::RST_DATA, dst_data)
    `EXPECT("reset flags", cscu_pkg::RST_FLAGS, flags_out)
    `EXPECT("reset pulses", 3'h0, {res_valid, dst_wr, reserved_op})
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, well beyond the roughly one thousand cycles of the full run
  initial begin
    #40000;
    n_fail++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    `EXPECT("reset valid", 1'b0, res_valid)
    t_check();
    t_cmp();
    t_bit();
    t_lz();
    t_frame();
    t_set();
    t_rst();
    end_sim();
  end
endmodule
